// ===== logic/rst_stby_pkg.sv
package rst_stby_pkg;
   // ==========================================
   // Register indices and fields
   localparam logic [15:0] stby_ctrl_off = 16'h0018;
   localparam logic [15:0] misc_ctrl_off = 16'h001a;
   localparam logic [15:0] stby_sel_off = 16'h0028;
   localparam int soft_stby_req_pos = 0;
   localparam int frame_align_pos = 1;
   localparam int inhibit_pos = 2;
   localparam int stby_done_pos = 14;
   localparam int soft_rst_pos = 0;
   localparam int out_en_pos = 1;
   localparam int shutdown_sel_pos = 0;
   localparam logic [15:0] stby_ctrl_rst = 16'h0000;
   localparam logic [15:0] misc_ctrl_rst = 16'h0218;
   localparam logic [15:0] stby_sel_rst = 16'h0001;
   localparam logic [15:0] pll_cfg_off = 16'h0010;
   localparam logic [15:0] pll_cfg_rst = 16'h0000;
   // ==========================================
   // Timing
   localparam int clk_mhz = 200;
   localparam int stby_entry_us = 20;
   localparam int stby_entry_cyc = stby_entry_us * clk_mhz;
   localparam int rst_seq_cyc = 100;
   localparam int sync_stages = 2;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;
endpackage

// ===== logic/sensor_reset_standby_ctrl.sv
`timescale 1ns/100ps
module sensor_reset_standby_ctrl (
   input wire logic clk_sys_i, // System clock
   input wire logic srst_i, // Synchronous reset
   input wire logic reset_pin_n_i, // Hard reset pin, active low
   input wire logic standby_pin_i, // Hard standby pin
   input wire logic line_end_i, // End of current line pulse
   input wire logic frame_end_i, // End of current frame pulse
   input wire logic calc_busy_i, // Statistics calculations in progress
   input wire logic core_active_i, // Sensor core still running
   input wire logic [15:0] reg_addr_i, // Register address
   input wire logic [15:0] reg_wdata_i, // Register write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [15:0] reg_rdata_o, // Read data, one cycle after strobe
   output logic logic_rst_o, // Reset to device logic
   output logic clk_gate_o, // Internal clocks gated off
   output logic vdd_off_o, // Digital power removed
   output logic serial_en_o, // Serial interface enabled
   output logic core_dis_req_o, // Request to disable sensor core
   output logic fifo_en_o, // Output FIFO enable
   output logic out_oe_o // Output pads enable
);
   // ==========================================
   // Pin synchronisers
   logic [1:0] rst_sync_q;
   logic [1:0] stby_sync_q;
   logic dev_rst;
   logic soft_rst_q;
   logic [7:0] soft_cnt_q;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rst_sync_q <= 2'h0;
         stby_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], reset_pin_n_i};
         stby_sync_q <= {stby_sync_q[0], standby_pin_i};
      end
   end

   // Soft reset and hard reset share one path so their effects match
   assign dev_rst = srst_i || !rst_sync_q[1] || soft_rst_q;

   // ==========================================
   // Register file
   logic soft_req_q;
   logic frame_align_q;
   logic inhibit_q;
   logic out_en_q;
   logic shutdown_sel_q;
   logic [15:0] pll_cfg_q;
   logic stby_done_q;
   logic wr_stby, wr_misc, wr_sel;
   logic serial_ok;

   // Serial port dead in hard standby; writes then ignored
   assign serial_ok = serial_en_o;
   assign wr_stby = reg_wr_i && serial_ok && reg_addr_i == rst_stby_pkg::stby_ctrl_off;
   assign wr_misc = reg_wr_i && serial_ok && reg_addr_i == rst_stby_pkg::misc_ctrl_off;
   assign wr_sel = reg_wr_i && serial_ok && reg_addr_i == rst_stby_pkg::stby_sel_off;

   typedef enum logic [2:0] {run_st, soft_wait_st, soft_gate_st, soft_st, hret_st, hoff_st} stby_state_type;
   stby_state_type state_q;

   // Shutdown pins every register but the PLL word at its reset value
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst || state_q == hoff_st) begin
         soft_req_q <= rst_stby_pkg::stby_ctrl_rst[rst_stby_pkg::soft_stby_req_pos];
         frame_align_q <= rst_stby_pkg::stby_ctrl_rst[rst_stby_pkg::frame_align_pos];
         inhibit_q <= rst_stby_pkg::stby_ctrl_rst[rst_stby_pkg::inhibit_pos];
         out_en_q <= rst_stby_pkg::misc_ctrl_rst[rst_stby_pkg::out_en_pos] & 1'b0;
         shutdown_sel_q <= rst_stby_pkg::stby_sel_rst[rst_stby_pkg::shutdown_sel_pos];
      end else begin
         if (wr_stby) begin
            soft_req_q <= reg_wdata_i[rst_stby_pkg::soft_stby_req_pos];
            frame_align_q <= reg_wdata_i[rst_stby_pkg::frame_align_pos];
            inhibit_q <= reg_wdata_i[rst_stby_pkg::inhibit_pos];
         end
         if (wr_misc) begin
            out_en_q <= reg_wdata_i[rst_stby_pkg::out_en_pos];
         end
         if (wr_sel) begin
            shutdown_sel_q <= reg_wdata_i[rst_stby_pkg::shutdown_sel_pos];
         end
      end
   end

   // PLL settings survive shutdown standby; hard and soft reset both clear them
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         pll_cfg_q <= rst_stby_pkg::pll_cfg_rst;
      end else if (reg_wr_i && serial_ok && reg_addr_i == rst_stby_pkg::pll_cfg_off) begin
         pll_cfg_q <= reg_wdata_i;
      end
   end

   // Soft reset pulse, held for the reset sequence length
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !rst_sync_q[1]) begin
         soft_rst_q <= 1'b0;
         soft_cnt_q <= 8'h00;
      end else if (soft_rst_q) begin
         if (soft_cnt_q == 8'(rst_stby_pkg::rst_seq_cyc - 1)) begin
            soft_rst_q <= 1'b0;
            soft_cnt_q <= 8'h00;
         end else begin
            soft_cnt_q <= soft_cnt_q + 8'h01;
         end
      end else if (wr_misc && reg_wdata_i[rst_stby_pkg::soft_rst_pos]) begin
         soft_rst_q <= 1'b1;
      end
   end

   // ==========================================
   // Standby sequencer
   logic [15:0] entry_cnt_q;
   logic soft_point;
   assign soft_point = frame_align_q ? frame_end_i : line_end_i;

   // Hard pin wins over a pending soft request while running
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         state_q <= run_st;
      end else begin
         unique case (state_q)
            run_st: begin
               if (stby_sync_q[1] && !inhibit_q) begin
                  state_q <= shutdown_sel_q ? hoff_st : hret_st;
               end else if (soft_req_q && !inhibit_q) begin
                  state_q <= soft_wait_st;
               end
            end
            soft_wait_st: begin
               if (!soft_req_q) begin
                  state_q <= run_st;
               end else if (soft_point && !calc_busy_i && !core_active_i) begin
                  state_q <= soft_gate_st;
               end
            end
            soft_gate_st: begin
               if (!soft_req_q) begin
                  state_q <= run_st;
               end else if (entry_cnt_q == 16'(rst_stby_pkg::stby_entry_cyc - 1)) begin
                  state_q <= soft_st;
               end
            end
            soft_st: begin
               if (!soft_req_q) begin
                  state_q <= run_st;
               end
            end
            hret_st, hoff_st: begin
               if (!stby_sync_q[1]) begin
                  state_q <= run_st;
               end
            end
         endcase
      end
   end

   // Counter idles outside gating, so a cancelled entry restarts from zero
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst || state_q != soft_gate_st) begin
         entry_cnt_q <= 16'h0000;
      end else begin
         entry_cnt_q <= entry_cnt_q + 16'h0001;
      end
   end

   // Done lags the state by a cycle, so the gate is already up when it rises
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         stby_done_q <= 1'b0;
      end else begin
         stby_done_q <= state_q == soft_st || state_q == hret_st;
      end
   end

   // ==========================================
   // Outputs
   assign logic_rst_o = dev_rst;
   assign clk_gate_o = state_q == soft_gate_st || state_q == soft_st || state_q == hret_st
      || state_q == hoff_st;
   assign vdd_off_o = state_q == hoff_st;
   assign serial_en_o = !(state_q == hret_st || state_q == hoff_st);
   assign core_dis_req_o = state_q == soft_wait_st || state_q == soft_gate_st || state_q == soft_st;

   // Pads drive only while running; any standby or reset floats them
   always_ff @(posedge clk_sys_i) begin
      if (dev_rst) begin
         fifo_en_o <= 1'b0;
         out_oe_o <= 1'b0;
         reg_rdata_o <= 16'h0000;
      end else begin
         fifo_en_o <= out_en_q && state_q == run_st;
         out_oe_o <= out_en_q && state_q == run_st;
         reg_rdata_o <= 16'h0000;
         if (reg_rd_i && serial_ok) begin
            unique case (reg_addr_i)
               rst_stby_pkg::stby_ctrl_off: reg_rdata_o <= 16'({stby_done_q, 11'h000, inhibit_q,
                  frame_align_q, soft_req_q}) << 0 | (16'(stby_done_q) << rst_stby_pkg::stby_done_pos)
                  & 16'h4000 | 16'({inhibit_q, frame_align_q, soft_req_q});
               rst_stby_pkg::misc_ctrl_off: reg_rdata_o <= rst_stby_pkg::misc_ctrl_rst & 16'hfffc
                  | 16'({out_en_q, 1'b0});
               rst_stby_pkg::stby_sel_off: reg_rdata_o <= 16'(shutdown_sel_q);
               rst_stby_pkg::pll_cfg_off: reg_rdata_o <= pll_cfg_q;
               default: reg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // ==========================================
   // Checks
   a_inhibit_blocks: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == run_st && inhibit_q |=> state_q == run_st)
      else $error("standby entered while inhibited");
   a_serial_off_hard: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      (state_q == hret_st || state_q == hoff_st) |-> !serial_en_o)
      else $error("serial active in hard standby");
   a_default_shutdown: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == run_st && stby_sync_q[1] && !inhibit_q && shutdown_sel_q |=> vdd_off_o)
      else $error("default standby not shutdown");
   a_done_after_gate: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      $rose(stby_done_q) |-> $past(clk_gate_o))
      else $error("done before clocks gated");
   a_soft_keeps_serial: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_st |-> serial_en_o && clk_gate_o)
      else $error("soft standby serial or gate wrong");
   a_outputs_reset: assert property (@(posedge clk_sys_i) dev_rst |=> !out_oe_o && !fifo_en_o)
      else $error("outputs enabled after reset");
   a_soft_rst_len: assert property (@(posedge clk_sys_i) disable iff (srst_i || !rst_sync_q[1])
      $rose(soft_rst_q) |-> soft_rst_q [*8])
      else $error("soft reset too short");
   a_pin_release: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == hret_st && !stby_sync_q[1] |=> state_q == run_st)
      else $error("no resume on pin release");
   // Entry must wait for every gating condition
   a_line_align: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_wait_st && !frame_align_q && !line_end_i |=> state_q != soft_gate_st)
      else $error("soft standby entered before line end");
   a_frame_align: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_wait_st && frame_align_q && !frame_end_i |=> state_q != soft_gate_st)
      else $error("soft standby entered before frame end");
   a_calc_first: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_wait_st && (calc_busy_i || core_active_i) |=> state_q != soft_gate_st)
      else $error("soft standby entered while busy");
   a_entry_time: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_gate_st && entry_cnt_q != 16'(rst_stby_pkg::stby_entry_cyc - 1) |=> state_q != soft_st)
      else $error("soft standby entry too short");
   a_soft_exit: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == soft_st && !soft_req_q |=> state_q == run_st)
      else $error("no exit on cleared request");
   a_done_clears: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == run_st |=> !stby_done_q)
      else $error("done flag left set while running");
   a_pads_standby: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q != run_st |=> !out_oe_o && !fifo_en_o)
      else $error("outputs driven in standby");
   // ==========================================
   // Retention and loss
   a_retention_keeps: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == hret_st |=> $stable(out_en_q) && $stable(shutdown_sel_q) && $stable(soft_req_q))
      else $error("register changed in retention");
   a_shutdown_clears: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == hoff_st |=> !out_en_q && shutdown_sel_q && !soft_req_q)
      else $error("register kept in shutdown");
   a_pll_kept: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == hoff_st |=> $stable(pll_cfg_q))
      else $error("pll setting lost in shutdown");
   a_shutdown_exit: assert property (@(posedge clk_sys_i) disable iff (dev_rst)
      state_q == hoff_st && !stby_sync_q[1] |=> state_q == run_st)
      else $error("no exit from shutdown on pin release");
endmodule

// ===== verif/host_model.sv
`timescale 1ns/100ps
// ==========================================
// Host side: reset and standby pins, register port
module host_model (
   input wire logic clk_i, // System clock
   input wire logic [15:0] rdata_i, // Read data
   output logic rst_pin_n_o, // Hard reset pin, active low
   output logic stby_pin_o, // Hard standby pin
   output rst_stby_pkg::reg_req_type req_o // Register request
);
   initial begin
      rst_pin_n_o = 1'b1;
      stby_pin_o = 1'b0;
      req_o = '0;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req_o.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_o.rd <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
   // Clock never stops, so the margins around both pin edges hold
   task automatic hard_reset();
      @(posedge clk_i);
      rst_pin_n_o <= 1'b0;
      repeat (70) @(posedge clk_i);
      rst_pin_n_o <= 1'b1;
      repeat (100) @(posedge clk_i);
   endtask
   task automatic soft_reset();
      wr(rst_stby_pkg::misc_ctrl_off, 16'h0219);
      wr(rst_stby_pkg::misc_ctrl_off, 16'h0218);
      repeat (100) @(posedge clk_i);
   endtask
   task automatic hard_standby(input int hold);
      @(posedge clk_i);
      stby_pin_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      stby_pin_o <= 1'b0;
   endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); \
      end \
   end
module testbench;
   logic clk, srst, line_end, frame_end, calc_busy, core_active, rst_pin_n, stby_pin;
   rst_stby_pkg::reg_req_type req;
   logic [15:0] rdata, v;
   logic logic_rst, clk_gate, vdd_off, serial_en, fifo_en, out_oe, core_dis;
   int num_errors = 0;
   int checks_done = 0;
   host_model host (.clk_i(clk), .rdata_i(rdata), .rst_pin_n_o(rst_pin_n), .stby_pin_o(stby_pin), .req_o(req));
   sensor_reset_standby_ctrl uut (.clk_sys_i(clk), .srst_i(srst), .reset_pin_n_i(rst_pin_n),
      .standby_pin_i(stby_pin), .line_end_i(line_end), .frame_end_i(frame_end), .calc_busy_i(calc_busy),
      .core_active_i(core_active), .reg_addr_i(req.addr), .reg_wdata_i(req.wdata), .reg_wr_i(req.wr),
      .reg_rd_i(req.rd), .reg_rdata_o(rdata), .logic_rst_o(logic_rst), .clk_gate_o(clk_gate),
      .vdd_off_o(vdd_off), .serial_en_o(serial_en), .core_dis_req_o(core_dis), .fifo_en_o(fifo_en),
      .out_oe_o(out_oe));
   // ==========================================
   // Helpers
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic rchk(input logic [15:0] a, input logic [15:0] e);
      host.rd(a, v);
      `CHK(v, e)
   endtask
   // Order: reset, gate, power off, serial, fifo, pads
   task automatic ochk(input logic [5:0] e);
      @(negedge clk);
      `CHK({logic_rst, clk_gate, vdd_off, serial_en, fifo_en, out_oe}, e)
   endtask
   task automatic pulse(input bit frame);
      @(posedge clk);
      if (frame) begin
         frame_end <= 1'b1;
      end else begin
         line_end <= 1'b1;
      end
      @(posedge clk);
      frame_end <= 1'b0;
      line_end <= 1'b0;
   endtask
   // Busy statistics first, so an early entry would show
   task automatic soft_stby(input logic [15:0] ctl, input bit frame);
      @(posedge clk);
      calc_busy <= 1'b1;
      core_active <= 1'b1;
      host.wr(rst_stby_pkg::stby_ctrl_off, ctl);
      pulse(frame);
      ochk(6'b000100);
      `CHK(core_dis, 1'b1)
      @(posedge clk);
      calc_busy <= 1'b0;
      core_active <= 1'b0;
      pulse(1'b0);
      ochk({1'b0, !frame, 4'b0100});
      if (frame) pulse(1'b1);
      repeat (3) @(posedge clk);
      ochk(6'b010100);
      repeat (3880) @(posedge clk);
      rchk(rst_stby_pkg::stby_ctrl_off, ctl);
      repeat (200) @(posedge clk);
      rchk(rst_stby_pkg::stby_ctrl_off, ctl | 16'h4000);
      repeat (20000) @(posedge clk);
      host.wr(rst_stby_pkg::stby_ctrl_off, 16'h0000);
      repeat (2) @(posedge clk);
      ochk(6'b000100);
      `CHK(core_dis, 1'b0)
      rchk(rst_stby_pkg::stby_ctrl_off, 16'h0000);
      $display("test soft standby done");
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   // ==========================================
   // Tests
   initial begin
      {srst, line_end, frame_end, calc_busy, core_active} = 5'b10000;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      ochk(6'b000100);
      host.hard_reset();
      rchk(rst_stby_pkg::stby_ctrl_off, rst_stby_pkg::stby_ctrl_rst);
      rchk(rst_stby_pkg::misc_ctrl_off, rst_stby_pkg::misc_ctrl_rst);
      rchk(rst_stby_pkg::stby_sel_off, rst_stby_pkg::stby_sel_rst);
      rchk(16'h0004, 16'h0000);
      $display("test reset values done");
      soft_stby(16'h0001, 1'b0);
      soft_stby(16'h0003, 1'b1);
      host.wr(rst_stby_pkg::stby_ctrl_off, 16'h0005);
      pulse(1'b0);
      repeat (3) @(posedge clk);
      ochk(6'b000100);
      `CHK(core_dis, 1'b0)
      host.wr(rst_stby_pkg::stby_ctrl_off, 16'h0000);
      $display("test inhibit done");
      host.wr(rst_stby_pkg::pll_cfg_off, 16'h1234);
      host.wr(rst_stby_pkg::misc_ctrl_off, 16'h021a);
      @(posedge clk);
      ochk(6'b000111);
      fork
         host.hard_standby(20000);
         begin
            repeat (20) @(posedge clk);
            @(negedge clk);
            `CHK({clk_gate, vdd_off, serial_en, fifo_en}, 4'b1100)
         end
      join
      repeat (100) @(posedge clk);
      rchk(rst_stby_pkg::pll_cfg_off, 16'h1234);
      rchk(rst_stby_pkg::misc_ctrl_off, rst_stby_pkg::misc_ctrl_rst);
      $display("test hard shutdown done");
      host.wr(rst_stby_pkg::stby_sel_off, 16'h0000);
      host.wr(rst_stby_pkg::misc_ctrl_off, 16'h021a);
      fork
         host.hard_standby(20000);
         begin
            repeat (20) @(posedge clk);
            @(negedge clk);
            `CHK({clk_gate, vdd_off, serial_en, fifo_en}, 4'b1000)
            host.wr(rst_stby_pkg::misc_ctrl_off, 16'h0218);
         end
      join
      repeat (10) @(posedge clk);
      ochk(6'b000111);
      rchk(rst_stby_pkg::stby_sel_off, 16'h0000);
      $display("test hard retention done");
      fork
         host.hard_reset();
         begin
            repeat (40) @(posedge clk);
            @(negedge clk);
            `CHK(logic_rst, 1'b1)
         end
      join
      ochk(6'b000100);
      rchk(rst_stby_pkg::stby_sel_off, rst_stby_pkg::stby_sel_rst);
      rchk(rst_stby_pkg::pll_cfg_off, rst_stby_pkg::pll_cfg_rst);
      $display("test hard reset done");
      host.wr(rst_stby_pkg::stby_sel_off, 16'h0000);
      host.wr(rst_stby_pkg::pll_cfg_off, 16'h1234);
      host.wr(rst_stby_pkg::misc_ctrl_off, 16'h021a);
      fork
         host.soft_reset();
         begin
            repeat (20) @(posedge clk);
            @(negedge clk);
            `CHK(logic_rst, 1'b1)
         end
      join
      ochk(6'b000100);
      rchk(rst_stby_pkg::stby_sel_off, rst_stby_pkg::stby_sel_rst);
      rchk(rst_stby_pkg::pll_cfg_off, rst_stby_pkg::pll_cfg_rst);
      $display("test soft reset done");
      give_verdict();
   end
endmodule
